//--- adc_seq_defines.svh
// Offsets, field positions, reset values and timing counts for the converter control block.
// Assumes a 32-bit Wishbone bus, one register to each aligned word.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
// Register indices; byte address is four times the index
`define IDX_PORT_ANALOG_CONFIG   8'hae
`define IDX_MODE_CONTROL         8'hb1
`define IDX_RESULT_HIGH          8'hb2
`define IDX_CLOCK_RESULT_LOW     8'hb3
`define ADR_WIDTH                12
// Mode register fields
`define MODE_ENABLE_BIT          7
`define MODE_START_BIT           6
`define MODE_DONE_BIT            5
`define MODE_GATE_BIT            4
`define MODE_RESET               8'h00
// Clock and low-result register fields
`define CLK_SEL_HI_BIT           6
`define CLK_RES_BIT              5
`define CLK_SEL_LO_BIT           4
`define CLKCFG_RESET             3'h0
`define ANALOG_CFG_RESET         8'h00
// Converter clock divide limits (divide ratio minus one)
`define DIV_LIMIT_16             4'hf
`define DIV_LIMIT_8              4'h7
`define DIV_LIMIT_1              4'h0
`define DIV_LIMIT_2              4'h1
// 16 periods of converter clock / 4
`define CONV_QUARTER_PERIODS     16
`define CONV_CLK_PER_PERIOD      4
`define CONV_TICKS               (`CONV_QUARTER_PERIODS * `CONV_CLK_PER_PERIOD)
`define NUM_INPUTS               8
`endif

//--- adc_seq_pkg.sv
// Types shared by the converter control block.
// Uses nothing from adc_seq_defines.svh; the state codes are numeric constants set here.
package adc_seq_pkg;
  typedef struct packed {
    logic       enable;
    logic       start;
    logic       done;
    logic       gate;
    logic [3:0] input_select;
  } mode_t;
  typedef struct packed {
    logic sel_hi;
    logic resolution;
    logic sel_lo;
  } clkcfg_t;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01
  } conv_state_t;
endpackage

//--- adc_sequencer_control.sv
// Control, timing and result registers for an eight-input 12-bit converter.
// Assumes a classic Wishbone master and an external analog core that presents its code on conv_code_i.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

// Functional notes
// [RULE1] Conversion starts only when a write sets gate and start together.
// [RULE2] At completion done rises and the 12-bit code is captured.
// [RULE3] Done reads zero while converting; completion sets done and clears start.
// [RULE4] Start bit is bit 6 of mode register: 0 stop, 1 converting.
// [RULE5] Gate bit 4 low disconnects all inputs; high connects the selected one.
// [RULE6] Select codes 0000 to 0111 route inputs zero to seven.
// [RULE7] Enable changes no pin direction or pull-up; software sets the pin.
// [RULE8] Clock select 00 /16, 01 /8, 10 undivided, 11 /2.
// [RULE9] Resolution bit 5: zero 8-bit, one 12-bit.
// [RULE10] Low nibble bits 3..0 are read-only result bits 3..0.
// [RULE11] High byte is read-only result bits 11..4.
// [RULE12] 8-bit mode updates high byte only; 12-bit mode updates both.
// [RULE13] Unsigned code, 4096 steps, zero to all ones.
// [RULE14] High byte is not reset.
// [RULE15] Low nibble is not reset; clock and resolution bits reset to zero.
// [RULE16] Only the selected pin is connected; others stay digital.
// [RULE17] Analog-config bit one blocks digital use of its pin; reset zero.
// [RULE18] Set analog-config bit isolates the whole digital input path.
// [RULE19] Software wanting middle resolution uses 12-bit and drops low bits.
// [RULE20] Conversion lasts 64 converter clock cycles.
// [RULE21] Writing start one clears done until the new conversion ends; the code clears done only when the same write also sets gate, in idle.
// [RULE22] High byte and low nibble update together at conversion end.
module adc_sequencer_control #(
  parameter int CONV_TICKS = `CONV_TICKS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [`ADR_WIDTH-1:0]  adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  input  wire logic [11:0]            conv_code_i,
  output logic                        converter_enable_o,
  output logic                        conv_sample_o,
  output logic [`NUM_INPUTS-1:0]      analog_connect_o,
  output logic [`NUM_INPUTS-1:0]      digital_isolate_o
);
  import adc_seq_pkg::*;

  localparam logic [`ADR_WIDTH-1:0] ADR_CFG  = `ADR_WIDTH'(`IDX_PORT_ANALOG_CONFIG * 4);
  localparam logic [`ADR_WIDTH-1:0] ADR_MODE = `ADR_WIDTH'(`IDX_MODE_CONTROL * 4);
  localparam logic [`ADR_WIDTH-1:0] ADR_HIGH = `ADR_WIDTH'(`IDX_RESULT_HIGH * 4);
  localparam logic [`ADR_WIDTH-1:0] ADR_LOW  = `ADR_WIDTH'(`IDX_CLOCK_RESULT_LOW * 4);

  mode_t       mode_reg;
  clkcfg_t     clkcfg_reg;
  logic [7:0]  analog_cfg_reg;
  logic [7:0]  result_high_reg;
  logic [3:0]  result_low_reg;
  conv_state_t state_reg;
  logic [3:0]  div_cnt_reg;
  logic [6:0]  tick_cnt_reg;
  logic [11:0] code_meta_reg;
  logic [11:0] code_sync_reg;
  logic        wr_ok;
  logic        wr_mode;
  logic        tick;
  logic        finish;
  logic        start_req;
  logic        stop_req;
  mode_t       wmode;

  // Divide limit for the two clock select bits
  function automatic logic [3:0] div_limit(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00:   div_limit = `DIV_LIMIT_16;
      2'b01:   div_limit = `DIV_LIMIT_8;
      2'b10:   div_limit = `DIV_LIMIT_1;
      default: div_limit = `DIV_LIMIT_2;
    endcase
  endfunction

  // Writes land at the edge where the master sees ack, so a dropped request never half-writes
  assign wr_ok     = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign wr_mode   = wr_ok && (adr_i == ADR_MODE);
  assign wmode     = mode_t'(dat_i[7:0]);
  assign start_req = wr_mode && wmode.start && wmode.gate && (state_reg == ST_IDLE); // RULE1
  assign stop_req  = wr_mode && !wmode.start;
  assign tick      = (state_reg == ST_CONVERT) &&
                     (div_cnt_reg == div_limit(clkcfg_reg.sel_hi, clkcfg_reg.sel_lo)); // RULE8
  assign finish    = tick && (tick_cnt_reg == 7'(CONV_TICKS - 1)); // RULE20

  // Wishbone ack: one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      if (adr_i == ADR_CFG) begin
        dat_o <= {24'h00_0000, analog_cfg_reg};
      end else if (adr_i == ADR_MODE) begin
        dat_o <= {24'h00_0000, mode_reg};
      end else if (adr_i == ADR_HIGH) begin
        dat_o <= {24'h00_0000, result_high_reg}; // RULE11
      end else if (adr_i == ADR_LOW) begin
        dat_o <= {24'h00_0000, 1'b0, clkcfg_reg.sel_hi, clkcfg_reg.resolution,
                  clkcfg_reg.sel_lo, result_low_reg}; // RULE10
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  // Analog configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_cfg_reg <= `ANALOG_CFG_RESET; // RULE17
    end else if (wr_ok && (adr_i == ADR_CFG)) begin
      analog_cfg_reg <= dat_i[7:0];
    end
  end

  // Clock select and resolution; low nibble is read-only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clkcfg_reg <= clkcfg_t'(`CLKCFG_RESET); // RULE15
    end else if (wr_ok && (adr_i == ADR_LOW)) begin
      clkcfg_reg.sel_hi     <= dat_i[`CLK_SEL_HI_BIT];
      clkcfg_reg.resolution <= dat_i[`CLK_RES_BIT]; // RULE9
      clkcfg_reg.sel_lo     <= dat_i[`CLK_SEL_LO_BIT];
    end
  end

  // Mode register; completion wins over a software write of start in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= mode_t'(`MODE_RESET);
    end else begin
      if (wr_mode) begin
        mode_reg.enable       <= wmode.enable;
        mode_reg.gate         <= wmode.gate;
        mode_reg.input_select <= wmode.input_select;
      end
      if (finish) begin
        mode_reg.done  <= 1'b1; // RULE3
        mode_reg.start <= 1'b0; // RULE3
      end else if (start_req) begin
        mode_reg.start <= 1'b1; // RULE4
        mode_reg.done  <= 1'b0; // RULE21
      end else if (stop_req) begin
        mode_reg.start <= 1'b0; // RULE4
      end
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          // Clearing start or gate aborts; the result stays as it was
          if (finish || stop_req || (wr_mode && !wmode.gate)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Converter clock divider and tick counter
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg != ST_CONVERT)) begin
      div_cnt_reg  <= 4'h0;
      tick_cnt_reg <= 7'h00;
    end else if (tick) begin
      div_cnt_reg  <= 4'h0;
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end else begin
      div_cnt_reg  <= div_cnt_reg + 4'h1;
    end
  end

  // Code from the analog core is asynchronous; two stages before use
  always_ff @(posedge clk_i) begin
    code_meta_reg <= conv_code_i;
    code_sync_reg <= code_meta_reg;
  end

  // Result registers carry no reset, so the high byte reads unknown until the first conversion, the low nibble until the first 12-bit one
  always_ff @(posedge clk_i) begin
    if (finish) begin
      result_high_reg <= code_sync_reg[11:4]; // RULE2 RULE13 RULE14 RULE22
      if (clkcfg_reg.resolution) begin
        result_low_reg <= code_sync_reg[3:0]; // RULE12 RULE15
      end
    end
  end

  // Pin side controls; enable touches no pin direction or pull-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_enable_o <= 1'b0;
      conv_sample_o      <= 1'b0;
      analog_connect_o   <= '0;
      digital_isolate_o  <= '0;
    end else begin
      converter_enable_o <= mode_reg.enable; // RULE7
      conv_sample_o      <= (state_reg == ST_CONVERT);
      digital_isolate_o  <= analog_cfg_reg; // RULE18
      for (int i = 0; i < `NUM_INPUTS; i++) begin
        // Select codes above seven connect nothing
        analog_connect_o[i] <= mode_reg.gate &&
                               (mode_reg.input_select == 4'(i)); // RULE5 RULE6 RULE16
      end
    end
  end

  // Helper: clock cycles spent in one conversion
  logic [11:0] conv_cycles_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg != ST_CONVERT)) begin
      conv_cycles_reg <= 12'h000;
    end else begin
      conv_cycles_reg <= conv_cycles_reg + 12'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_gated: assert property (state_reg == ST_IDLE ##1 state_reg == ST_CONVERT |-> $past(wr_mode && wmode.gate && wmode.start)) // RULE1
    else $error("conversion started without gate");
  a_done_captures: assert property (finish |=> mode_reg.done && result_high_reg == $past(code_sync_reg[11:4])) // RULE2
    else $error("done or result missing at completion");
  a_start_autoclr: assert property ($rose(mode_reg.done) |-> !mode_reg.start && state_reg == ST_IDLE) // RULE3
    else $error("start not cleared at completion");
  a_done_low_busy: assert property (state_reg == ST_CONVERT |-> !mode_reg.done) // RULE3
    else $error("done high while converting");
  a_start_clr_done: assert property (start_req |=> !mode_reg.done [*2]) // RULE21
    else $error("done not cleared by start");
  a_conv_length: assert property (finish |-> conv_cycles_reg ==
      12'(CONV_TICKS * (div_limit(clkcfg_reg.sel_hi, clkcfg_reg.sel_lo) + 1) - 1)) // RULE20
    else $error("conversion length wrong");
  a_connect_one: assert property (##1 $onehot0(analog_connect_o)) // RULE16
    else $error("more than one input connected");
  a_connect_gate: assert property (!mode_reg.gate |=> analog_connect_o == '0) // RULE5
    else $error("input connected with gate low");
  a_low_hold8: assert property (finish && !clkcfg_reg.resolution |=> $stable(result_low_reg)) // RULE12
    else $error("low nibble changed in 8-bit mode");
  a_result_atomic: assert property (!finish |=> $stable(result_high_reg) && $stable(result_low_reg)) // RULE22
    else $error("result changed outside completion");
  a_isolate_map: assert property (##1 digital_isolate_o == $past(analog_cfg_reg)) // RULE18
    else $error("isolation does not follow config");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");

  c_full_conv: cover property (start_req ##[1:1000] finish);
  c_fast_conv: cover property (finish && clkcfg_reg.sel_hi && !clkcfg_reg.sel_lo);
  c_abort: cover property (state_reg == ST_CONVERT && stop_req);
  c_8bit: cover property (finish && !clkcfg_reg.resolution);
endmodule

//--- adc_analog_src.sv
// Analog side model: eight input levels and the converter core code.
// Assumes the block drives at most one connect line at a time.
`timescale 1ns/10ps
module adc_analog_src (
  input  wire logic [7:0]  connect_i,
  input  wire logic [95:0] levels_i,
  output logic      [11:0] code_o
);
  logic [11:0] last_code;
  initial last_code = 12'h000;
  always_comb begin
    // Nothing connected: a stale level would hide a wrong capture
    code_o = ~last_code;
    for (int n = 0; n < 8; n++) begin
      if (connect_i[n]) begin
        code_o = levels_i[n*12 +: 12];
      end
    end
  end
  always @(code_o) if (|connect_i) last_code = code_o;
endmodule

//--- adc_sequencer_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the analog side model and a shortened conversion count.
`timescale 1ns/10ps
module adc_sequencer_control_tb_top;
  localparam int T = 4;
  localparam logic [11:0] A_CFG = 12'h2b8, A_MODE = 12'h2c4, A_HI = 12'h2c8, A_LO = 12'h2cc;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, en_o, busy_o;
  logic [11:0] adr_i, code;
  logic [3:0]  sel_i, nib;
  logic [31:0] dat_i, dat_o, rng;
  logic [7:0]  conn_o, iso_o, acfg, hb;
  logic [95:0] levels;
  logic [7:0]  exp_q[$], msk_q[$];
  int          failures, checks_done;
  adc_sequencer_control #(.CONV_TICKS(T)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .conv_code_i(code), .converter_enable_o(en_o), .conv_sample_o(busy_o),
    .analog_connect_o(conn_o), .digital_isolate_o(iso_o));
  adc_analog_src u_src (.connect_i(conn_o), .levels_i(levels), .code_o(code));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) failures++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    wb(1'b0, a, 8'h00);
  endtask
  // Read results are judged where they appear, against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i && exp_q.size() > 0) begin
      chk(dat_o & {24'hff_ffff, msk_q[0]}, {24'h00_0000, exp_q[0]});
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task automatic conv(input logic [1:0] cs, input logic res, input int d);
    logic [3:0]  ch;
    logic [11:0] v;
    int n;
    rng = xs(rng);
    ch = {1'b0, rng[2:0]};
    v = rng[19:8];
    levels[ch*12 +: 12] <= v;
    wb(1'b1, A_LO, {1'b0, cs[1], res, cs[0], 4'h0});
    wb(1'b1, A_MODE, {4'h9, ch});
    // Pin controls are registered one cycle after the write
    @(posedge clk_i);
    chk(conn_o, 8'h01 << ch);
    chk(iso_o, acfg);
    wb(1'b1, A_MODE, {4'hd, ch});
    n = 0;
    while (busy_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (busy_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n), 32'(T * d));
    hb = v[11:4];
    if (res) nib = v[3:0];
    rd(A_MODE, {4'hb, ch}, 8'hff);
    rd(A_HI, hb, 8'hff);
    rd(A_LO, {1'b0, cs[1], res, cs[0], nib}, 8'h7f);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    levels = '0;
    rng = 32'h0000_99a1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_MODE, 8'h00, 8'hff);
    rd(A_CFG, 8'h00, 8'hff);
    rd(A_LO, 8'h00, 8'h70);
    rd(12'h000, 8'h00, 8'hff);
    rng = xs(rng);
    acfg = rng[7:0];
    wb(1'b1, A_CFG, acfg);
    rd(A_CFG, acfg, 8'hff);
    @(posedge clk_i);
    chk(iso_o, acfg);
    conv(2'b00, 1'b1, 16);
    conv(2'b01, 1'b1, 8);
    conv(2'b10, 1'b1, 1);
    conv(2'b11, 1'b1, 2);
    conv(2'b10, 1'b0, 1);
    wb(1'b1, A_HI, 8'hff);
    rd(A_HI, hb, 8'hff);
    wb(1'b1, A_MODE, 8'hc3);
    rd(A_MODE, 8'h20, 8'h70);
    wb(1'b1, A_LO, 8'h20);
    wb(1'b1, A_MODE, 8'hd3);
    rd(A_MODE, 8'hd3, 8'hff);
    wb(1'b1, A_MODE, 8'h83);
    rd(A_MODE, 8'h83, 8'hff);
    rd(A_HI, hb, 8'hff);
    report_and_stop();
  end
endmodule
